// ---- hdl/lss_cfg.svh ----
// constants of the line controlled set sequencer
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

`define LSS_CLK_NS       250
`define LSS_CLK_PS       4000
`define LSS_SETTLE_NS    100
`define LSS_SETTLE_CYC   ((`LSS_SETTLE_NS * 1000 + `LSS_CLK_PS - 1) / `LSS_CLK_PS)
`define LSS_LOAD_CYC     2
`define LSS_TMR_W        8

`define LSS_NSETS        16
`define LSS_IDX_W        4
`define LSS_CNT_W        5
`define LSS_DW           32
`define LSS_AW           8

`define LSS_ADR_CTRL     8'h00
`define LSS_ADR_COUNT    8'h04
`define LSS_ADR_STATUS   8'h08
`define LSS_ADR_ACTIVE   8'h0c
`define LSS_ADR_SAVED    8'h10
`define LSS_SET_REGION   2'h1

`define LSS_CTRL_EN      0
`define LSS_CTRL_ADV_SEL 1
`define LSS_CTRL_RST_EN  2
`define LSS_CTRL_INV1    3
`define LSS_CTRL_INV2    4
`define LSS_CTRL_FALL    5
`define LSS_CTRL_W       6
`define LSS_CTRL_RST     6'h00
`define LSS_COUNT_RST    5'h10
`define LSS_ACTIVE_RST   32'h0000_0000

`define LSS_ST_WAIT_BIT  0
`define LSS_ST_SEQ_BIT   1
`define LSS_ST_IGN_BIT   2
`define LSS_ST_IDX_LSB   4
`define LSS_ST_STATE_LSB 8

`endif

// ---- hdl/lss_pkg.sv ----
// types of the line controlled set sequencer
`include "lss_cfg.svh"

package lss_pkg;

    typedef enum logic [1:0] {
        LSS_ST_WAIT   = 2'b00,
        LSS_ST_SETTLE = 2'b01,
        LSS_ST_LOAD   = 2'b10,
        LSS_ST_ACQ    = 2'b11
    } lss_state_type;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } lss_sync_type;

    typedef struct packed {
        logic [`LSS_CTRL_W-1:0] ctrl;
        logic [`LSS_CNT_W-1:0]  count;
        logic                   ack;
        logic [`LSS_DW-1:0]     dat;
    } lss_wb_type;

    typedef struct packed {
        lss_state_type                          state;
        logic [`LSS_TMR_W-1:0]                  timer;
        logic                                   seq_on;
        logic [`LSS_IDX_W-1:0]                  idx;
        logic [`LSS_DW-1:0]                     active;
        logic [`LSS_DW-1:0]                     saved;
        logic [`LSS_NSETS-1:0][`LSS_DW-1:0]     mem;
        logic                                   trig_d;
        logic [1:0]                             lines_d;
        logic                                   ign;
        logic                                   acq_start;
    } lss_core_type;

endpackage : lss_pkg

// ---- hdl/lss_if.sv ----
// register side to sequencer core signals
`timescale 1ns/1ns
`default_nettype none
`include "lss_cfg.svh"

interface lss_if;
    logic [`LSS_CTRL_W-1:0] ctrl;
    logic [`LSS_CNT_W-1:0]  count;
    logic                   act_we;
    logic                   mem_we;
    logic [`LSS_IDX_W-1:0]  mem_addr;
    logic [`LSS_DW-1:0]     wdata;
    logic [`LSS_DW-1:0]     wmask;
    logic                   ign_clr;
    logic [`LSS_DW-1:0]     status;
    logic [`LSS_DW-1:0]     active;
    logic [`LSS_DW-1:0]     saved;

    modport regs (
        output ctrl, count, act_we, mem_we, mem_addr, wdata, wmask, ign_clr,
        input  status, active, saved
    );
    modport core (
        input  ctrl, count, act_we, mem_we, mem_addr, wdata, wmask, ign_clr,
        output status, active, saved
    );
endinterface : lss_if

`default_nettype wire

// ---- hdl/lss_sync.sv ----
// two flip-flop synchroniser for the trigger and control pins
`timescale 1ns/1ns
`default_nettype none

module lss_sync (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] pins,
    output logic      [2:0] pins_s
);
    lss_pkg::lss_sync_type s_r;
    lss_pkg::lss_sync_type s_nxt;

    always_comb
    begin
        s_nxt.stage1 = pins;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign pins_s = s_r.stage2;
endmodule : lss_sync

`default_nettype wire

// ---- hdl/lss_wb.sv ----
// classic wishbone register slave of the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "lss_cfg.svh"

module lss_wb (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [`LSS_AW-1:0] wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [`LSS_DW-1:0] wb_dat_i,
    output logic      [`LSS_DW-1:0] wb_dat_o,
    output logic                    wb_ack_o,
    lss_if.regs                     rif
);
    lss_pkg::lss_wb_type s_r;
    lss_pkg::lss_wb_type s_nxt;
    logic               req;
    logic               wr;
    logic [`LSS_DW-1:0] mask;

    assign req  = wb_cyc_i & wb_stb_i;
    // writes land on the edge where ack is sampled
    assign wr   = req & wb_we_i & s_r.ack;
    assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb
    begin
        s_nxt     = s_r;
        s_nxt.ack = req & ~s_r.ack;
        s_nxt.dat = '0;
        if (req & ~s_r.ack & ~wb_we_i)
        begin
            unique case (wb_adr_i)
                `LSS_ADR_CTRL:   s_nxt.dat[`LSS_CTRL_W-1:0] = s_r.ctrl;
                `LSS_ADR_COUNT:  s_nxt.dat[`LSS_CNT_W-1:0] = s_r.count;
                `LSS_ADR_STATUS: s_nxt.dat = rif.status;
                `LSS_ADR_ACTIVE: s_nxt.dat = rif.active;
                `LSS_ADR_SAVED:  s_nxt.dat = rif.saved;
                default:         s_nxt.dat = '0;
            endcase
        end
        if (wr && wb_adr_i == `LSS_ADR_CTRL)
            s_nxt.ctrl = (s_r.ctrl & ~mask[`LSS_CTRL_W-1:0])
                       | (wb_dat_i[`LSS_CTRL_W-1:0] & mask[`LSS_CTRL_W-1:0]);
        if (wr && wb_adr_i == `LSS_ADR_COUNT)
            s_nxt.count = (s_r.count & ~mask[`LSS_CNT_W-1:0])
                        | (wb_dat_i[`LSS_CNT_W-1:0] & mask[`LSS_CNT_W-1:0]);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r       <= '0;
            s_r.ctrl  <= `LSS_CTRL_RST;
            s_r.count <= `LSS_COUNT_RST;
        end
        else
            s_r <= s_nxt;
    end

    assign wb_ack_o     = s_r.ack;
    assign wb_dat_o     = s_r.dat;
    assign rif.ctrl     = s_r.ctrl;
    assign rif.count    = s_r.count;
    assign rif.wdata    = wb_dat_i;
    assign rif.wmask    = mask;
    assign rif.act_we   = wr && wb_adr_i == `LSS_ADR_ACTIVE;
    assign rif.mem_we   = wr && wb_adr_i[7:6] == `LSS_SET_REGION;
    assign rif.mem_addr = wb_adr_i[5:2];
    assign rif.ign_clr  = wr && wb_adr_i == `LSS_ADR_STATUS && wb_dat_i[`LSS_ST_IGN_BIT]
                          && wb_sel_i[0];
endmodule : lss_wb

`default_nettype wire

// ---- hdl/lss_top.sv ----
// line controlled parameter set sequencer, top level
`timescale 1ns/1ns
`default_nettype none
`include "lss_cfg.svh"

module lss_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`LSS_AW-1:0]    wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [`LSS_DW-1:0]    wb_dat_i,
    output logic      [`LSS_DW-1:0]    wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  frame_trig,
    input  wire logic                  ctl_line1,
    input  wire logic                  ctl_line2,
    input  wire logic                  acq_done,
    output logic                       acq_start,
    output logic      [`LSS_DW-1:0]    active_set,
    output logic      [`LSS_IDX_W-1:0] set_index,
    output logic                       waiting_trig,
    output logic                       seq_active
);
    logic [1:0]            rst_pipe_r;
    logic                  rst_sync_n;
    logic [2:0]            pins_s;
    logic                  trig_s;
    logic [1:0]            lines_s;
    logic [1:0]            asserted;
    logic                  adv_line;
    logic                  rst_line;
    logic                  trig_edge;
    logic                  lines_moved;
    logic [`LSS_IDX_W-1:0] last_idx;
    logic [`LSS_IDX_W-1:0] next_idx;
    logic                  want_on;
    lss_pkg::lss_core_type s_r;
    lss_pkg::lss_core_type s_nxt;

    lss_if rif ();

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe_r <= 2'h0;
        else
            rst_pipe_r <= {rst_pipe_r[0], 1'h1};
    end

    assign rst_sync_n = rst_pipe_r[1];

    lss_sync u_sync (
        .clk    (ref_clk),
        .rst_n  (rst_sync_n),
        .pins   ({ctl_line2, ctl_line1, frame_trig}),
        .pins_s (pins_s)
    );

    lss_wb u_wb (
        .clk      (ref_clk),
        .rst_n    (rst_sync_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rif      (rif)
    );

    assign trig_s  = pins_s[0];
    assign lines_s = pins_s[2:1];

    // polarity per line
    assign asserted[0] = lines_s[0] ^ rif.ctrl[`LSS_CTRL_INV1];
    assign asserted[1] = lines_s[1] ^ rif.ctrl[`LSS_CTRL_INV2];

    // advance from the selected line, restart from the other one
    assign adv_line = asserted[rif.ctrl[`LSS_CTRL_ADV_SEL]];
    assign rst_line = rif.ctrl[`LSS_CTRL_RST_EN]
                    & asserted[~rif.ctrl[`LSS_CTRL_ADV_SEL]];

    // edge select; default is rising
    assign trig_edge = rif.ctrl[`LSS_CTRL_FALL] ? (s_r.trig_d & ~trig_s)
                                                : (~s_r.trig_d & trig_s);

    assign lines_moved = lines_s != s_r.lines_d;

    // highest legal index from the set count
    always_comb
    begin
        if (rif.count == '0)
            last_idx = '0;
        else if (rif.count >= `LSS_CNT_W'(`LSS_NSETS))
            last_idx = `LSS_IDX_W'(`LSS_NSETS - 1);
        else
            last_idx = `LSS_IDX_W'(rif.count - `LSS_CNT_W'(1));
    end

    // index chosen at a trigger
    always_comb
    begin
        if (rst_line)
            next_idx = '0;
        else if (adv_line && s_r.idx >= last_idx)
            next_idx = '0;
        else if (adv_line)
            next_idx = s_r.idx + `LSS_IDX_W'(1);
        else
            next_idx = s_r.idx;
    end

    assign want_on = rif.ctrl[`LSS_CTRL_EN];

    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.trig_d    = trig_s;
        s_nxt.lines_d   = lines_s;
        s_nxt.acq_start = 1'h0;

        // set storage writes at any time, direct active writes only while the sequencer is off
        if (rif.mem_we)
            s_nxt.mem[rif.mem_addr] = (s_r.mem[rif.mem_addr] & ~rif.wmask)
                                    | (rif.wdata & rif.wmask);
        if (rif.act_we && !s_r.seq_on)
            s_nxt.active = (s_r.active & ~rif.wmask) | (rif.wdata & rif.wmask);

        // sticky ignored-trigger flag, a new one beats the clear
        if (rif.ign_clr)
            s_nxt.ign = 1'h0;
        if (trig_edge && s_r.state != lss_pkg::LSS_ST_WAIT)
            s_nxt.ign = 1'h1;

        unique case (s_r.state)
            lss_pkg::LSS_ST_WAIT:
            begin
                if (want_on && !s_r.seq_on)
                begin
                    // remember prior parameters, start the cycle at set 0
                    s_nxt.saved  = s_r.active;
                    s_nxt.active = s_r.mem[0];
                    s_nxt.idx    = '0;
                    s_nxt.seq_on = 1'h1;
                    s_nxt.state  = lss_pkg::LSS_ST_LOAD;
                    s_nxt.timer  = `LSS_TMR_W'(`LSS_LOAD_CYC);
                end
                else if (!want_on && s_r.seq_on)
                begin
                    s_nxt.active = s_r.saved;
                    s_nxt.seq_on = 1'h0;
                    s_nxt.state  = lss_pkg::LSS_ST_LOAD;
                    s_nxt.timer  = `LSS_TMR_W'(`LSS_LOAD_CYC);
                end
                else if (trig_edge)
                begin
                    if (s_r.seq_on)
                    begin
                        s_nxt.idx    = next_idx;
                        s_nxt.active = s_r.mem[next_idx];
                    end
                    s_nxt.acq_start = 1'h1;
                    s_nxt.state     = lss_pkg::LSS_ST_ACQ;
                end
                else if (lines_moved)
                begin
                    s_nxt.state = lss_pkg::LSS_ST_SETTLE;
                    s_nxt.timer = `LSS_TMR_W'(`LSS_SETTLE_CYC);
                end
            end

            lss_pkg::LSS_ST_SETTLE:
            begin
                // a further change restarts the settle time
                if (lines_moved)
                    s_nxt.timer = `LSS_TMR_W'(`LSS_SETTLE_CYC);
                else if (s_r.timer <= `LSS_TMR_W'(1))
                    s_nxt.state = lss_pkg::LSS_ST_WAIT;
                else
                    s_nxt.timer = s_r.timer - `LSS_TMR_W'(1);
            end

            lss_pkg::LSS_ST_LOAD:
            begin
                if (s_r.timer <= `LSS_TMR_W'(1))
                    s_nxt.state = lss_pkg::LSS_ST_WAIT;
                else
                    s_nxt.timer = s_r.timer - `LSS_TMR_W'(1);
            end

            lss_pkg::LSS_ST_ACQ:
            begin
                if (acq_done)
                begin
                    if (!want_on && s_r.seq_on)
                    begin
                        // disable takes effect once the frame is over
                        s_nxt.active = s_r.saved;
                        s_nxt.seq_on = 1'h0;
                        s_nxt.state  = lss_pkg::LSS_ST_LOAD;
                        s_nxt.timer  = `LSS_TMR_W'(`LSS_LOAD_CYC);
                    end
                    else
                        s_nxt.state = lss_pkg::LSS_ST_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s_r        <= '0;
            s_r.active <= `LSS_ACTIVE_RST;
            s_r.state  <= lss_pkg::LSS_ST_WAIT;
        end
        else
            s_r <= s_nxt;
    end

    // status word towards software
    always_comb
    begin
        rif.status = '0;
        rif.status[`LSS_ST_WAIT_BIT] = s_r.state == lss_pkg::LSS_ST_WAIT;
        rif.status[`LSS_ST_SEQ_BIT]  = s_r.seq_on;
        rif.status[`LSS_ST_IGN_BIT]  = s_r.ign;
        rif.status[`LSS_ST_IDX_LSB +: `LSS_IDX_W] = s_r.idx;
        rif.status[`LSS_ST_STATE_LSB +: 2]        = s_r.state;
    end

    assign rif.active   = s_r.active;
    assign rif.saved    = s_r.saved;

    assign acq_start    = s_r.acq_start;
    assign active_set   = s_r.active;
    assign set_index    = s_r.idx;
    assign waiting_trig = s_r.state == lss_pkg::LSS_ST_WAIT;
    assign seq_active   = s_r.seq_on;
endmodule : lss_top

`default_nettype wire

// ---- test/lss_chk.sv ----
// assertions on the set sequencer top ports
`timescale 1ns/1ns
`default_nettype none
module lss_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        frame_trig,
    input wire logic        ctl_line1,
    input wire logic        ctl_line2,
    input wire logic        acq_start,
    input wire logic [31:0] active_set,
    input wire logic [3:0]  set_index,
    input wire logic        waiting_trig,
    input wire logic        seq_active
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_line_move;
        $changed(ctl_line1) || $changed(ctl_line2);
    endsequence
    sequence s_leave_wait;
        ##[1:6] !waiting_trig ##1 !waiting_trig [*8];
    endsequence

    a_start_pulse: assert property (acq_start |=> !acq_start)
        else $error("start pulse longer than one cycle");
    a_start_in_wait: assert property (acq_start |-> $past(waiting_trig) && !waiting_trig)
        else $error("start outside waiting state");
    a_rise_only: assert property (acq_start |-> $past(frame_trig, 2) && !$past(frame_trig, 7))
        else $error("start without rising trigger");
    a_index_step: assert property (acq_start && seq_active |-> set_index == 4'h0
        || set_index == $past(set_index) || set_index == $past(set_index) + 4'h1)
        else $error("index moved by more than one");
    a_off_keep: assert property (acq_start && !seq_active |-> $stable(active_set))
        else $error("active word changed while sequencer off");
    a_line_leave: assert property (s_line_move ##0 waiting_trig |-> s_leave_wait)
        else $error("line change did not leave waiting state");
    a_wait_back: assert property ($fell(waiting_trig) |-> ##[1:300] waiting_trig)
        else $error("waiting state not regained");
    a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer missing or too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
endmodule : lss_chk
`default_nettype wire

// ---- test/lss_src_model.sv ----
// trigger and control line source driving the sequencer pins
`timescale 1ns/1ns
`default_nettype none
module lss_src_model (
    input  wire logic ref_clk,
    input  wire logic waiting,
    output var logic  frame_trig,
    output var logic  ctl_line1,
    output var logic  ctl_line2
);
    initial
    begin
        frame_trig = 1'b0;
        ctl_line1  = 1'b0;
        ctl_line2  = 1'b0;
    end

    // rude skips the settle wait so the trigger lands while settling
    task automatic fire(input logic [1:0] lv, input logic rude);
        int n;
        n = 0;
        ctl_line1 <= lv[0];
        ctl_line2 <= lv[1];
        if (rude)
            repeat (6) @(posedge ref_clk);
        else
        begin
            repeat (40) @(posedge ref_clk); // lines well ahead
            while (waiting !== 1'b1 && n < 100)
            begin
                @(posedge ref_clk);
                n++;
            end
        end
        frame_trig <= 1'b1;
        repeat (250) @(posedge ref_clk); // trigger held high 1 us
        frame_trig <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : fire
endmodule : lss_src_model
`default_nettype wire

// ---- test/tb_line_controlled_set_sequencer.sv ----
// self-checking bench of the set sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_line_controlled_set_sequencer;
    logic        ref_clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        trig;
    logic        ln1;
    logic        ln2;
    logic        done;
    logic        start;
    logic [31:0] act;
    logic [3:0]  idx;
    logic        wait_t;
    logic        seq;
    logic [31:0] rd;
    logic        got;
    int          num_errors;
    int          n_checks;
    logic [1:0]  lvs [15] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 2'h3,
                              2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
    logic [3:0]  ixs [15] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h1, 4'h2, 4'h3, 4'h0,
                              4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0};

    lss_top dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .frame_trig(trig), .ctl_line1(ln1),
        .ctl_line2(ln2), .acq_done(done), .acq_start(start), .active_set(act),
        .set_index(idx), .waiting_trig(wait_t), .seq_active(seq)
    );
    lss_src_model src_u (
        .ref_clk(ref_clk), .waiting(wait_t), .frame_trig(trig),
        .ctl_line1(ln1), .ctl_line2(ln2)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // only the watchdog ends a missing answer
        do
            @(posedge ref_clk);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_io

    task automatic wait_start(output logic g);
        g = 1'b0;
        for (int n = 0; n < 400 && !g; n++)
        begin
            @(posedge ref_clk);
            g = (start === 1'b1);
        end
    endtask : wait_start

    task automatic wait_rdy;
        repeat (4) @(posedge ref_clk);
        for (int n = 0; n < 200 && wait_t !== 1'b1; n++)
            @(posedge ref_clk);
    endtask : wait_rdy

    // one trigger with the given line levels, then finish the frame
    task automatic shot(input logic [1:0] lv, input logic [3:0] ex, input logic [31:0] ea);
        fork
            src_u.fire(lv, 1'b0);
            begin
                wait_start(got);
                chk({31'h0, got}, 32'h1);
                chk({28'h0, idx}, {28'h0, ex});
                chk(act, ea);
                done <= 1'b1;
                @(posedge ref_clk);
                done <= 1'b0;
            end
        join
    endtask : shot

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish;
    end

    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        done = 1'b0;
        num_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wb_io(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        wb_io(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h10);
        wb_io(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        wb_io(1'b1, 8'h0c, 32'habcd0000);
        for (int i = 0; i < 6; i++)
            wb_io(1'b1, 8'h40 + 8'(4 * i), 32'h1000 + i);
        wb_io(1'b0, 8'h44, 32'h0);
        chk(rd, 32'h0);
        wb_io(1'b1, 8'h04, 32'h6);
        shot(2'h0, 4'h0, 32'habcd0000);
        wb_io(1'b1, 8'h00, 32'h5);
        wait_rdy;
        chk(act, 32'h1000);
        chk({28'h0, idx}, 32'h0);
        wb_io(1'b0, 8'h10, 32'h0);
        chk(rd, 32'habcd0000);
        for (int k = 0; k < 15; k++)
            shot(lvs[k], ixs[k], 32'h1000 + ixs[k]);
        fork
            src_u.fire(2'h0, 1'b1);
            wait_start(got);
        join
        chk({31'h0, got}, 32'h0);
        chk({28'h0, idx}, 32'h0);
        wb_io(1'b0, 8'h08, 32'h0);
        chk(rd & 32'h4, 32'h4);
        wb_io(1'b1, 8'h08, 32'h4);
        wb_io(1'b0, 8'h08, 32'h0);
        chk(rd & 32'h4, 32'h0);
        wb_io(1'b1, 8'h00, 32'h7);
        shot(2'h2, 4'h1, 32'h1001);
        shot(2'h3, 4'h0, 32'h1000);
        wb_io(1'b1, 8'h00, 32'h0);
        wait_rdy;
        chk(act, 32'habcd0000);
        chk({31'h0, seq}, 32'h0);
        tally_and_finish;
    end
endmodule : tb_line_controlled_set_sequencer

bind lss_top lss_chk chk_u (
    .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .frame_trig,
    .ctl_line1, .ctl_line2, .acq_start, .active_set, .set_index, .waiting_trig, .seq_active
);
`default_nettype wire
